// File: logic/gctl_pkg.sv
// package for the global switch control bank: offsets, fields, resets,
// timing counts and the frame descriptor types.
// assumes a 125 MHz core clock and a 32-bit axi4-lite register bus.
`default_nettype none
package gctl_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_GC0 = 8'h02;
  localparam logic [7:0] IDX_GC1 = 8'h03;
  localparam logic [9:0] ADDR_GC0 = {IDX_GC0, 2'b00};
  localparam logic [9:0] ADDR_GC1 = {IDX_GC1, 2'b00};
  // field positions, first register
  localparam int B_MII_EN = 3;
  localparam int B_BUF_SHARE = 2;
  localparam int B_CONF_DROP = 1;
  localparam int B_LINK_AGE = 0;
  // field positions, second register
  localparam int B_PASS_ALL = 7;
  localparam int B_TX_FC_DIS = 5;
  localparam int B_RX_FC_DIS = 4;
  localparam int B_LEN_CHK = 3;
  localparam int B_AGE_EN = 2;
  localparam int B_FAST_AGE = 1;
  // writable bits; the rest read as zero
  localparam logic [7:0] GC0_MASK = 8'h0f;
  localparam logic [7:0] GC1_MASK = 8'hbe;
  // reset values before the straps are folded in
  localparam logic [7:0] GC0_RST = 8'h0c;
  localparam logic [7:0] GC1_RST = 8'h04;
  // frame constants
  localparam logic [15:0] MAC_CTL_TYPE = 16'h8808;
  localparam logic [47:0] PAUSE_DA = 48'h0180c2000001;
  localparam logic [15:0] LEN_LIMIT = 16'h05dc;
  // timing
  localparam int CLK_NS = 8;
  localparam int FAST_AGE_NS = 800000;
  localparam int FAST_AGE_CYC = FAST_AGE_NS / CLK_NS;
  localparam longint NORMAL_AGE_S = 300;
  localparam longint NORMAL_AGE_CYC = NORMAL_AGE_S * 64'd1000000000 / CLK_NS;
  // port counts and widths
  localparam int NPORT = 5;
  localparam int MII_W = 9;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // frame seen by the filter
  typedef struct packed {
    logic valid;
    logic [15:0] type_len;
    logic [47:0] dest;
    logic [15:0] payload_len;
    logic flow_ctl;
    logic bad;
  } frame_t;
  // filter verdict
  typedef struct packed {
    logic valid;
    logic drop;
  } verdict_t;
endpackage : gctl_pkg
`default_nettype wire

// File: logic/switch_global_control_bits.sv
// global control bank of a five-port switch: two byte registers behind
// axi4-lite, strap-loaded defaults, mii isolation, frame filter,
// flow-control gating and the address-table aging timer.
// assumes straps and link lines are asynchronous, all else on core_clk.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_bits
  import gctl_pkg::*;
#(
  parameter longint NORMAL_CYC = NORMAL_AGE_CYC,
  parameter int FAST_CYC = FAST_AGE_CYC,
  parameter logic [15:0] POOL_BLOCKS = 16'd500
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [9:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [9:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mii_enable_strap,
  input wire logic aging_enable_strap,
  input wire logic flow_control_strap,
  input wire logic [MII_W-1:0] mii_src,
  output logic [MII_W-1:0] mii_out,
  output logic mii_oe_b,
  output logic [15:0] port_quota,
  input wire frame_t frame_in,
  output verdict_t verdict,
  input wire logic [NPORT-1:0] autoneg_result_tx,
  input wire logic [NPORT-1:0] autoneg_result_rx,
  output logic [NPORT-1:0] tx_fc_en,
  output logic [NPORT-1:0] rx_fc_en,
  input wire logic [NPORT-1:0] link_up,
  output logic age_tick,
  output logic age_all
);
  // register storage
  logic [7:0] gc0_q;
  logic [7:0] gc1_q;
  // strap and link synchronisers; stage one feeds stage two only
  logic [2:0] strap_s1_q;
  logic [2:0] strap_s2_q;
  logic [NPORT-1:0] link_s1_q;
  logic [NPORT-1:0] link_s2_q;
  logic [NPORT-1:0] link_s3_q;
  // first cycle after reset release loads the straps
  logic strap_pend_q;
  // write channel holding
  logic aw_have_q;
  logic w_have_q;
  logic [9:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  // aging timer
  logic [35:0] age_cnt_q;
  logic fast_pend_q;
  logic age_tick_q;
  logic age_all_q;
  // registered outputs
  logic [MII_W-1:0] mii_out_q;
  logic [15:0] quota_q;
  verdict_t verdict_q;
  logic [NPORT-1:0] tx_fc_q;
  logic [NPORT-1:0] rx_fc_q;
  // every check below runs on the core clock and sleeps through reset
  default clocking cb_core @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // decode helper: known index or not
  function automatic logic [1:0] sel_of(input logic [9:0] a);
    sel_of = {a == ADDR_GC1, a == ADDR_GC0};
  endfunction : sel_of

  // named control bits
  wire mii_en = gc0_q[B_MII_EN];
  wire buf_share = gc0_q[B_BUF_SHARE];
  wire conf_drop = gc0_q[B_CONF_DROP];
  wire link_age = gc0_q[B_LINK_AGE];
  wire pass_all = gc1_q[B_PASS_ALL];
  wire tx_fc_dis = gc1_q[B_TX_FC_DIS];
  wire rx_fc_dis = gc1_q[B_RX_FC_DIS];
  wire len_chk = gc1_q[B_LEN_CHK];
  wire age_en = gc1_q[B_AGE_EN];
  wire fast_age = gc1_q[B_FAST_AGE];

  // bus handshakes; a channel is refused while its slot is full
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  // write commits once both halves are held and no response waits
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire [1:0] wsel = sel_of(aw_addr_q);
  wire [1:0] rsel = sel_of(s_axi_araddr);
  wire wr_gc0 = do_write && wsel[0] && w_lane_q;
  wire wr_gc1 = do_write && wsel[1] && w_lane_q;
  wire [7:0] rd_byte = rsel[0] ? gc0_q : (rsel[1] ? gc1_q : 8'h00);

  // link loss on any port, seen on synchronised levels
  wire link_lost = |(link_s3_q & ~link_s2_q);
  wire loss_age = link_lost && link_age && age_en;
  wire fast_mode = fast_age || fast_pend_q;
  wire [35:0] period = fast_mode ? 36'(FAST_CYC) : 36'(NORMAL_CYC);
  wire age_wrap = age_en && (age_cnt_q >= period - 36'h1);

  // frame classification
  wire is_mac_ctl = conf_drop ?
    (frame_in.type_len == MAC_CTL_TYPE || frame_in.dest == PAUSE_DA) :
    frame_in.flow_ctl;
  wire len_bad = len_chk && frame_in.type_len < LEN_LIMIT &&
    frame_in.type_len != frame_in.payload_len;
  wire frm_drop = !pass_all && (is_mac_ctl || len_bad || frame_in.bad);

  // synchronisers have no reset; the strap load waits for stage two
  always_ff @(posedge core_clk) begin
    strap_s1_q <= {flow_control_strap, aging_enable_strap, mii_enable_strap};
    strap_s2_q <= strap_s1_q;
    link_s1_q <= link_up;
    link_s2_q <= link_s1_q;
    link_s3_q <= link_s2_q;
  end

  // first control register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gc0_q <= GC0_RST;
    end else if (strap_pend_q) begin
      gc0_q[B_MII_EN] <= strap_s2_q[0];
    end else if (wr_gc0) begin
      gc0_q <= w_data_q & GC0_MASK;
    end
  end

  // second control register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gc1_q <= GC1_RST;
    end else if (strap_pend_q) begin
      gc1_q[B_AGE_EN] <= strap_s2_q[1];
      gc1_q[B_TX_FC_DIS] <= strap_s2_q[2];
      gc1_q[B_RX_FC_DIS] <= strap_s2_q[2];
    end else if (wr_gc1) begin
      gc1_q <= w_data_q & GC1_MASK;
    end
  end

  // strap load flag, one cycle after release
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      strap_pend_q <= 1'b1;
    end else begin
      strap_pend_q <= 1'b0;
    end
  end

  // write address and data slots, filled in either order
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 10'h000;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= (|wsel) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read path, data in the low byte
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= (|rsel) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // aging timer; a link loss with link_age and age_en set restarts it in fast mode
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      age_cnt_q <= 36'h0;
      fast_pend_q <= 1'b0;
      age_tick_q <= 1'b0;
      age_all_q <= 1'b0;
    end else begin
      age_all_q <= loss_age;
      age_tick_q <= age_wrap && !loss_age;
      if (loss_age) begin
        age_cnt_q <= 36'h0;
        fast_pend_q <= 1'b1;
      end else if (age_wrap) begin
        age_cnt_q <= 36'h0;
        fast_pend_q <= 1'b0;
      end else if (age_en) begin
        age_cnt_q <= age_cnt_q + 36'h1;
      end
    end
  end

  // datapath controls, registered
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mii_out_q <= '0;
      quota_q <= POOL_BLOCKS;
      verdict_q <= '0;
      tx_fc_q <= '0;
      rx_fc_q <= '0;
    end else begin
      mii_out_q <= mii_src;
      quota_q <= buf_share ? POOL_BLOCKS : POOL_BLOCKS / 16'd5;
      verdict_q.valid <= frame_in.valid;
      verdict_q.drop <= frame_in.valid && frm_drop;
      tx_fc_q <= tx_fc_dis ? '0 : autoneg_result_tx;
      rx_fc_q <= rx_fc_dis ? '0 : autoneg_result_rx;
    end
  end

  // outputs
  assign mii_out = mii_out_q;
  assign mii_oe_b = !mii_en;
  assign port_quota = quota_q;
  assign verdict = verdict_q;
  assign tx_fc_en = tx_fc_q;
  assign rx_fc_en = rx_fc_q;
  assign age_tick = age_tick_q;
  assign age_all = age_all_q;

  // checks
  property p_mii_iso;
    wr_gc0 && !w_data_q[B_MII_EN] |=> mii_oe_b;
  endproperty
  a_mii_iso: assert property (p_mii_iso) else $error("mii not isolated");
  property p_strap_mii;
    strap_pend_q |=> mii_en == $past(strap_s2_q[0]) && mii_oe_b == !$past(strap_s2_q[0]);
  endproperty
  a_strap_mii: assert property (p_strap_mii) else $error("mii strap lost");
  property p_strap_fc;
    strap_pend_q |=> tx_fc_dis == rx_fc_dis ##1 (tx_fc_dis ? tx_fc_en == '0 : 1'b1);
  endproperty
  a_strap_fc: assert property (p_strap_fc) else $error("fc strap split");
  property p_quota;
    !buf_share ##1 !$past(strap_pend_q) |-> port_quota == POOL_BLOCKS / 16'd5;
  endproperty
  a_quota: assert property (p_quota) else $error("quota not a fifth");
  property p_conf_drop;
    frame_in.valid && conf_drop && !pass_all && frame_in.type_len == MAC_CTL_TYPE
      |=> verdict.valid && verdict.drop;
  endproperty
  a_conf_drop: assert property (p_conf_drop) else $error("8808 kept");
  property p_pass_all;
    frame_in.valid && pass_all |=> verdict.valid && !verdict.drop;
  endproperty
  a_pass_all: assert property (p_pass_all) else $error("frame dropped");
  property p_len_chk;
    frame_in.valid && !len_chk && !frame_in.bad && !is_mac_ctl |=> !verdict.drop;
  endproperty
  a_len_chk: assert property (p_len_chk) else $error("length drop off");
  property p_tx_fc;
    tx_fc_dis |=> tx_fc_en == '0;
  endproperty
  a_tx_fc: assert property (p_tx_fc) else $error("tx fc not off");
  property p_rx_fc;
    !rx_fc_dis |=> rx_fc_en == $past(autoneg_result_rx);
  endproperty
  a_rx_fc: assert property (p_rx_fc) else $error("rx fc wrong");
  sequence s_loss;
    loss_age;
  endsequence
  sequence s_flush_fast;
    age_all && fast_pend_q && age_cnt_q == 36'h0;
  endsequence
  property p_link_loss;
    s_loss |=> s_flush_fast;
  endproperty
  a_link_loss: assert property (p_link_loss) else $error("no flush");
  property p_age_off;
    !age_en && !$past(age_en) |-> !age_tick;
  endproperty
  a_age_off: assert property (p_age_off) else $error("aging while off");
  // a count frozen while aging was off may exceed the fast period for one cycle
  property p_fast_bound;
    fast_age && age_en |-> age_cnt_q < 36'(FAST_CYC) || $past(!(fast_age && age_en));
  endproperty
  a_fast_bound: assert property (p_fast_bound) else $error("fast overrun");
  property p_hold;
    !wr_gc1 && !strap_pend_q |=> $stable(gc1_q);
  endproperty
  a_hold: assert property (p_hold) else $error("register drifted");
  property p_index;
    ar_take && s_axi_araddr == ADDR_GC0 |=> s_axi_rdata[7:0] == $past(gc0_q);
  endproperty
  a_index: assert property (p_index) else $error("bad read index");
endmodule : switch_global_control_bits
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the global control bank: bus, straps, filter, aging
// assumes gctl_pkg and the bank compiled first; one 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gctl_pkg::*;
  logic core_clk = 0, rst_b = 0;
  logic [9:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  wire logic awready, wready, bvalid, arready, rvalid, oe_b, tick, flush;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  logic s_mii = 1, s_age = 1, s_fc = 0; // straps at their pull levels
  logic [MII_W-1:0] msrc = 9'h1a5;
  wire logic [MII_W-1:0] mout;
  wire logic [15:0] quota;
  frame_t fr = '0;
  wire verdict_t vd;
  logic [NPORT-1:0] nego_tx = 5'h15, nego_rx = 5'h0a, link = 5'h1f;
  wire logic [NPORT-1:0] txe, rxe;
  int err_total = 0, total_checks = 0, n;
  logic [1:0] rsp;
  logic [31:0] rv;
  // short aging periods keep the run small
  switch_global_control_bits #(.NORMAL_CYC(200), .FAST_CYC(20)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mii_enable_strap(s_mii), .aging_enable_strap(s_age), .flow_control_strap(s_fc),
    .mii_src(msrc), .mii_out(mout), .mii_oe_b(oe_b), .port_quota(quota),
    .frame_in(fr), .verdict(vd), .autoneg_result_tx(nego_tx), .autoneg_result_rx(nego_rx),
    .tx_fc_en(txe), .rx_fc_en(rxe), .link_up(link), .age_tick(tick), .age_all(flush));
  // free-running core clock
  always #4 core_clk = ~core_clk;
  // one compare for every kind of value
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bus write: aw and w offered together, each dropped when taken
  task wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1;
    wdata <= {24'h0, d};
    wstrb <= s;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 0;
  endtask : wr
  // bus read, then compare byte and response
  task rchk(input string nm, input logic [9:0] a, input logic [7:0] e, input logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rv = rdata;
    rsp = rresp;
    rready <= 0;
    chk(nm, {24'h0, e}, rv);
    chk("rresp", {30'h0, r}, {30'h0, rsp});
  endtask : rchk
  // one frame in, verdict judged a cycle later
  task frm(input logic [15:0] tl, input logic [47:0] da, input logic [15:0] ln,
           input logic fc, input logic bd, input logic e);
    @(posedge core_clk);
    fr <= '{1'b1, tl, da, ln, fc, bd};
    @(posedge core_clk);
    fr.valid <= 0;
    @(posedge core_clk);
    chk("drop", {31'h0, e}, {31'h0, vd.drop});
    chk("verdict_valid", 32'h1, {31'h0, vd.valid});
  endtask : frm
  // bounded wait for an aging pulse; f picks the flush pulse
  task wt(input logic f, output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      c++;
    end while (!(f ? flush : tick) && c < 1000);
  endtask : wt
  task t_reset;
    rchk("gc0", ADDR_GC0, 8'h0c, RESP_OKAY);
    rchk("gc1", ADDR_GC1, 8'h04, RESP_OKAY);
    chk("oe_b", 0, oe_b);
    chk("mii_out", msrc, mout);
    chk("quota", 500, quota);
    $display("test reset done");
  endtask : t_reset
  task t_regs;
    wr(ADDR_GC0, 8'hff, 4'h1);
    rchk("gc0_all", ADDR_GC0, 8'h0f, RESP_OKAY);
    wr(ADDR_GC1, 8'hff, 4'h1);
    rchk("gc1_all", ADDR_GC1, 8'hbe, RESP_OKAY);
    wr(ADDR_GC1, 8'h00, 4'h0); // strobe off leaves the byte alone
    chk("bresp", RESP_OKAY, rsp);
    rchk("gc1_kept", ADDR_GC1, 8'hbe, RESP_OKAY);
    wr(10'h010, 8'hff, 4'h1);
    chk("bresp_unmapped", RESP_SLVERR, rsp);
    rchk("unmapped", 10'h010, 8'h00, RESP_SLVERR);
    wr(ADDR_GC1, 8'h00, 4'h1);
    rchk("gc1_clr", ADDR_GC1, 8'h00, RESP_OKAY);
    $display("test regs done");
  endtask : t_regs
  task t_mii;
    wr(ADDR_GC0, 8'h07, 4'h1); // isolate the mii, pool still shared
    chk("oe_b_iso", 1, oe_b);
    wr(ADDR_GC0, 8'h0b, 4'h1);
    repeat (2) @(posedge core_clk);
    chk("quota_fifth", 500 / 5, quota);
    chk("oe_b_on", 0, oe_b);
    $display("test mii done");
  endtask : t_mii
  task t_filter;
    wr(ADDR_GC0, 8'h0c, 4'h1);
    frm(16'h0800, 48'h0, 16'h0, 1, 0, 1);
    frm(MAC_CTL_TYPE, 48'h0, 16'h0, 0, 0, 0);
    wr(ADDR_GC0, 8'h0e, 4'h1);
    frm(MAC_CTL_TYPE, 48'h0, 16'h0, 0, 0, 1);
    frm(16'h0800, PAUSE_DA, 16'h0, 0, 0, 1);
    frm(16'h0800, 48'h0, 16'h0, 1, 0, 0);
    frm(16'h0800, 48'h0, 16'h0, 0, 1, 1);
    wr(ADDR_GC1, 8'h08, 4'h1);
    frm(16'h0064, 48'h0, 16'h005a, 0, 0, 1);
    frm(16'h0064, 48'h0, 16'h0064, 0, 0, 0);
    frm(16'h05db, 48'h0, 16'h0000, 0, 0, 1);
    frm(16'h05dc, 48'h0, 16'h0000, 0, 0, 0);
    wr(ADDR_GC1, 8'h88, 4'h1);
    frm(16'h0064, 48'h0, 16'h005a, 0, 1, 0);
    frm(MAC_CTL_TYPE, 48'h0, 16'h0, 1, 0, 0);
    $display("test filter done");
  endtask : t_filter
  task t_fc;
    wr(ADDR_GC1, 8'h20, 4'h1);
    repeat (2) @(posedge core_clk);
    chk("tx_fc", 0, txe);
    chk("rx_fc", nego_rx, rxe);
    wr(ADDR_GC1, 8'h10, 4'h1);
    repeat (2) @(posedge core_clk);
    chk("tx_fc", nego_tx, txe);
    chk("rx_fc", 0, rxe);
    $display("test flow control done");
  endtask : t_fc
  task t_age;
    wr(ADDR_GC0, 8'h0c, 4'h1);
    wr(ADDR_GC1, 8'h04, 4'h1);
    wt(0, n);
    wt(0, n);
    chk("normal_period", 200, n);
    wt(0, n);
    wr(ADDR_GC1, 8'h06, 4'h1);
    wt(0, n);
    wt(0, n);
    chk("fast_period", 20, n);
    wr(ADDR_GC1, 8'h04, 4'h1);
    link <= 5'h1e; // link loss with the age-on-link bit clear
    wt(1, n);
    chk("no_flush", 1000, n);
    link <= 5'h1f;
    wr(ADDR_GC0, 8'h0d, 4'h1);
    wt(0, n);
    link <= 5'h0f;
    wt(1, n);
    chk("flush_soon", 1, n <= 10);
    wt(0, n);
    chk("fast_pass", 20, n);
    wt(0, n);
    chk("back_normal", 200, n);
    link <= 5'h1f;
    $display("test aging done");
  endtask : t_age
  task t_strap;
    @(posedge core_clk);
    rst_b <= 0;
    s_mii <= 0;
    s_age <= 0;
    s_fc <= 1;
    repeat (16) @(posedge core_clk);
    rst_b <= 1;
    repeat (3) @(posedge core_clk);
    rchk("gc0_strap", ADDR_GC0, 8'h04, RESP_OKAY);
    rchk("gc1_strap", ADDR_GC1, 8'h30, RESP_OKAY);
    chk("oe_b_strap", 1, oe_b);
    wt(0, n);
    chk("aging_off", 1000, n);
    $display("test straps done");
  endtask : t_strap
  // single exit for both the normal end and the watchdog
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // main sequence: reset held 16 cycles, then every test
  initial begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_regs();
    t_mii();
    t_filter();
    t_fc();
    t_age();
    t_strap();
    give_verdict();
  end
  // watchdog; the full sequence needs about a sixth of this
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
